// [logic/tcs_level_eval.sv]
/*
  Evaluates the four commands of all sixteen levels against one sample and
  picks out the active level. Purely combinational; assumes registered input.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tcs_regs.svh"
module tcs_level_eval (
  input wire tcs_pkg::tcs_level_s levelProg [`TCS_LEVELS],
  input wire logic [`TCS_LVL_W-1:0] curLevel,
  input wire logic [`TCS_CNT_W-1:0] sampleCount,
  input wire logic [`TCS_DATA_W-1:0] sample,
  output logic [`TCS_LVL_W-1:0] jumpTarget,
  output var tcs_pkg::tcs_cmd_s cmd
);
  tcs_pkg::tcs_cmd_s perLevel [`TCS_LEVELS];

  // All levels evaluated in parallel, same sample for all commands
  genvar gi;
  generate
    for (gi = 0; gi < `TCS_LEVELS; gi++) begin : gLevel
      always_comb begin
        perLevel[gi].stop = (((sample ^ levelProg[gi].stopVal) & levelProg[gi].stopMask) == '0)
                            && (sampleCount >= levelProg[gi].stopDelay);
        perLevel[gi].jump = (((sample ^ levelProg[gi].jumpVal) & levelProg[gi].jumpMask) == '0)
                            && (sampleCount >= levelProg[gi].jumpDelay);
        perLevel[gi].next_level_command = (((sample ^ levelProg[gi].advVal) & levelProg[gi].advMask) == '0)
                               && (sampleCount >= levelProg[gi].advDelay);
        // Own condition, independent of the sequencing ones
        perLevel[gi].trace = ((sample ^ levelProg[gi].traceVal) & levelProg[gi].traceMask) == '0;
      end
    end
  endgenerate

  // Active level selects its results
  assign cmd = perLevel[curLevel];
  assign jumpTarget = levelProg[curLevel].jumpTarget;
endmodule : tcs_level_eval
`default_nettype wire

// [logic/tcs_pkg.sv]
/*
  Types shared by the trace capture sequencer modules.
  Assumes tcs_regs.svh is on the include path.
*/
`include "tcs_regs.svh"
package tcs_pkg;
  typedef enum logic [1:0] {
    TCS_IDLE = 2'b00,
    TCS_RUN = 2'b01,
    TCS_COPY = 2'b10,
    TCS_DONE = 2'b11
  } tcs_phase_e;

  // One level's program: four condition slots, three delays and the jump target
  typedef struct packed {
    logic [`TCS_DATA_W-1:0] stopMask;
    logic [`TCS_DATA_W-1:0] stopVal;
    logic [`TCS_CNT_W-1:0] stopDelay;
    logic [`TCS_DATA_W-1:0] jumpMask;
    logic [`TCS_DATA_W-1:0] jumpVal;
    logic [`TCS_CNT_W-1:0] jumpDelay;
    logic [`TCS_LVL_W-1:0] jumpTarget;
    logic [`TCS_DATA_W-1:0] advMask;
    logic [`TCS_DATA_W-1:0] advVal;
    logic [`TCS_CNT_W-1:0] advDelay;
    logic [`TCS_DATA_W-1:0] traceMask;
    logic [`TCS_DATA_W-1:0] traceVal;
  } tcs_level_s;

  typedef struct packed {
    logic [`TCS_LVL_W-1:0] level;
    logic [`TCS_DATA_W-1:0] data;
  } tcs_word_s;

  // Command results of the active level
  typedef struct packed {
    logic stop;
    logic jump;
    logic next_level_command;
    logic trace;
  } tcs_cmd_s;
endpackage : tcs_pkg

// [logic/tcs_regs.svh]
/*
  Constants for the trace capture sequencer: widths, depths, pipeline length,
  reset values. Assumes inclusion by bare name from package and modules.
*/
// Contract
// - Each capture word holds the 48 probe bits and a four-bit trace level field.
// - Sixteen identical levels each evaluate stop, jump, next_level_command and trace together.
// - Only the trace command decides whether a sample is written to capture memory.
// - Stop, jump and next_level_command steer level movement and never decide storage.
// - A stop halts trace control and copies capture memory into display memory.
// - A sample counter cleared on every level entry is compared against each delay.
// - Capture memory is circular so the newest traced sample replaces the oldest.
// - Inputs are taken only on active edges of the selected sample clock.
// - A recording process is one or more cycles, repeated or not by arm mode.
// - Each memory is 515 words of 52 bits, 512 for events and three for pipeline; display memory here holds only the 512 event words.
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH
`define TCS_DATA_W 48
`define TCS_LVL_W 4
`define TCS_WORD_W 52
`define TCS_LEVELS 16
`define TCS_EVT_DEPTH 512
`define TCS_MEM_DEPTH 515
`define TCS_PIPE_WORDS 3
`define TCS_ADDR_W 10
`define TCS_CNT_W 16
`define TCS_LVL_RST 4'h0
`endif

// [logic/trace_capture_sequencer.sv]
/*
  Trace capture sequencer: samples 48 probe inputs on the selected sample
  clock, runs a sixteen-level trace control, stores traced samples in a
  circular capture memory and copies it to display memory on stop.
  The first three sample edges of every recording cycle only refill the
  pipeline, so no command ever judges a word left over from a past cycle.
  Assumes probes and sample clocks are asynchronous pins, levels are
  programmed statically while idle, and display reads are synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tcs_regs.svh"
module trace_capture_sequencer (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [`TCS_DATA_W-1:0] probeIn,
  input wire logic [1:0] sampleClkPins,
  input wire logic sampleClkSel,
  input wire logic sampleClkFalling,
  input wire logic armStart,
  input wire logic armRepeat,
  input wire tcs_pkg::tcs_level_s levelProg [`TCS_LEVELS],
  input wire logic [`TCS_ADDR_W-1:0] dispAddr,
  output logic [`TCS_WORD_W-1:0] dispData,
  output logic [`TCS_ADDR_W-1:0] dispOldest,
  output logic dispFull,
  output logic running,
  output logic recordDone,
  output logic [`TCS_LVL_W-1:0] curLevel
);
  typedef struct packed {
    tcs_pkg::tcs_phase_e phase;
    logic [`TCS_DATA_W-1:0] probeS1;
    logic [`TCS_DATA_W-1:0] probeS2;
    logic [1:0] clkS1;
    logic [1:0] clkS2;
    logic clkPrev;
    logic [`TCS_LVL_W-1:0] level;
    logic [`TCS_CNT_W-1:0] count;
    logic [1:0] pipeFill;
    logic [`TCS_ADDR_W-1:0] wrPtr;
    logic full;
    logic [`TCS_ADDR_W-1:0] copyIdx;
    logic [`TCS_ADDR_W-1:0] oldest;
    logic dispFullFlag;
    logic done;
    logic [`TCS_WORD_W-1:0] dispOut;
  } tcs_state_s;

  tcs_state_s stateReg;
  tcs_state_s stateNext;

  // Three pipeline words ahead of 512 capture words; display memory holds 512 only
  logic [`TCS_WORD_W-1:0] pipeMem [`TCS_PIPE_WORDS];
  logic [`TCS_WORD_W-1:0] captureMem [`TCS_EVT_DEPTH];
  logic [`TCS_WORD_W-1:0] displayMem [`TCS_EVT_DEPTH];

  localparam logic [`TCS_ADDR_W-1:0] LAST_ADDR = `TCS_ADDR_W'(`TCS_EVT_DEPTH - 1);

  logic selClk;
  logic clkEdge;
  tcs_pkg::tcs_cmd_s cmd;
  logic [`TCS_LVL_W-1:0] jumpTarget;
  logic captureWe;
  logic pipeReady;
  logic evalEdge;
  logic doStop;
  logic doJump;
  logic doAdvance;
  tcs_pkg::tcs_word_s evalWord;

  // Edge of the chosen clock, read only from the second stage
  assign selClk = stateReg.clkS2[sampleClkSel] ^ sampleClkFalling;
  assign clkEdge = selClk & ~stateReg.clkPrev;

  // Word under evaluation sits in the last pipeline stage
  assign evalWord = tcs_pkg::tcs_word_s'(pipeMem[`TCS_PIPE_WORDS-1]);

  // Stage three holds stale words right after entry; hold off every
  // command until samples of this cycle reach it
  assign pipeReady = (stateReg.pipeFill == 2'(`TCS_PIPE_WORDS));

  tcs_level_eval uEval (
    .levelProg(levelProg),
    .curLevel(stateReg.level),
    .sampleCount(stateReg.count),
    .sample(evalWord.data),
    .jumpTarget(jumpTarget),
    .cmd(cmd)
  );

  // Judged edge: running, a sample edge, and the pipeline refilled
  assign evalEdge = (stateReg.phase == tcs_pkg::TCS_RUN) && clkEdge && pipeReady;

  // Trace alone gates the store, regardless of sequencing commands
  assign captureWe = evalEdge && cmd.trace;

  // Sequencing picks one move per judged edge, stop first
  assign doStop = evalEdge && cmd.stop;
  assign doJump = evalEdge && cmd.jump && !cmd.stop;
  assign doAdvance = evalEdge && cmd.next_level_command && !cmd.stop && !cmd.jump;

  // Sample register takes the probes with the level tag at sampling
  always_ff @(posedge core_clk) begin
    if ((stateReg.phase == tcs_pkg::TCS_RUN) && clkEdge) begin
      pipeMem[0] <= {stateReg.level, stateReg.probeS2};
    end
  end

  // Two delay stages behind it, one per generate step; words hold no reset
  genvar gs;
  generate
    for (gs = 1; gs < `TCS_PIPE_WORDS; gs++) begin : gPipe
      always_ff @(posedge core_clk) begin
        if ((stateReg.phase == tcs_pkg::TCS_RUN) && clkEdge) begin
          pipeMem[gs] <= pipeMem[gs-1];
        end
      end
    end
  endgenerate

  // Capture write and copy read share one port; no reset on arrays
  always_ff @(posedge core_clk) begin
    if (captureWe) begin
      captureMem[stateReg.wrPtr[8:0]] <= evalWord;
    end
    if (stateReg.phase == tcs_pkg::TCS_COPY) begin
      displayMem[stateReg.copyIdx[8:0]] <= captureMem[stateReg.copyIdx[8:0]];
    end
  end

  // Next state
  always_comb begin
    stateNext = stateReg;
    stateNext.probeS1 = probeIn;
    stateNext.probeS2 = stateReg.probeS1;
    stateNext.clkS1 = sampleClkPins;
    stateNext.clkS2 = stateReg.clkS1;
    stateNext.clkPrev = selClk;
    stateNext.dispOut = displayMem[dispAddr[8:0]];
    case (stateReg.phase)
      tcs_pkg::TCS_IDLE: begin
        if (armStart) begin
          stateNext.phase = tcs_pkg::TCS_RUN;
          stateNext.level = `TCS_LVL_RST;
          stateNext.count = '0;
          stateNext.wrPtr = '0;
          stateNext.full = 1'b0;
          stateNext.pipeFill = 2'h0;
          stateNext.done = 1'b0;
        end
      end
      tcs_pkg::TCS_RUN: begin
        // Fill edges only shift the pipeline; nothing is judged or counted
        if (clkEdge && !pipeReady) begin
          stateNext.pipeFill = stateReg.pipeFill + 2'h1;
        end
        if (captureWe) begin
          // Wrap and overwrite the oldest word
          stateNext.wrPtr = (stateReg.wrPtr == LAST_ADDR) ? '0 : stateReg.wrPtr + 1'b1;
          if (stateReg.wrPtr == LAST_ADDR) begin
            stateNext.full = 1'b1;
          end
        end
        // Stop beats jump beats next_level_command; none touches storage
        if (doStop) begin
          stateNext.phase = tcs_pkg::TCS_COPY;
          stateNext.copyIdx = '0;
        end else if (doJump) begin
          stateNext.level = jumpTarget;
          stateNext.count = '0;
        end else if (doAdvance) begin
          stateNext.level = stateReg.level + 1'b1;
          stateNext.count = '0;
        end else if (evalEdge && (stateReg.count != '1)) begin
          // Saturates so a long wait never wraps back under a delay
          stateNext.count = stateReg.count + 1'b1;
        end
      end
      tcs_pkg::TCS_COPY: begin
        // One word per core cycle; display reads see words change as they are copied meanwhile
        stateNext.copyIdx = stateReg.copyIdx + 1'b1;
        if (stateReg.copyIdx == LAST_ADDR) begin
          stateNext.oldest = stateReg.full ? stateReg.wrPtr : '0;
          stateNext.dispFullFlag = stateReg.full;
          stateNext.phase = tcs_pkg::TCS_DONE;
        end
      end
      tcs_pkg::TCS_DONE: begin
        // Repeat arm starts another cycle, single arm ends the process
        if (armRepeat) begin
          stateNext.phase = tcs_pkg::TCS_RUN;
          stateNext.level = `TCS_LVL_RST;
          stateNext.count = '0;
          stateNext.wrPtr = '0;
          stateNext.full = 1'b0;
          stateNext.pipeFill = 2'h0;
        end else begin
          stateNext.done = 1'b1;
          stateNext.phase = tcs_pkg::TCS_IDLE;
        end
      end
      default: stateNext.phase = tcs_pkg::TCS_IDLE;
    endcase
  end

  // State register, constants only under reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Outputs come straight from the state flops, except running, which is decoded from the phase
  assign dispData = stateReg.dispOut;
  assign dispOldest = stateReg.oldest;
  assign dispFull = stateReg.dispFullFlag;
  assign running = (stateReg.phase == tcs_pkg::TCS_RUN);
  assign recordDone = stateReg.done;
  assign curLevel = stateReg.level;
endmodule : trace_capture_sequencer
`default_nettype wire

// [tb/tb.sv]
/*
  Self-checking bench for the trace capture sequencer.
  Assumes package, header, checker and probe model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sampleClkSel = 1'b0;
  logic sampleClkFalling = 1'b0;
  logic armStart = 1'b0;
  logic armRepeat = 1'b0;
  logic [9:0] dispAddr = 10'h000;
  logic rdValid = 1'b0;
  logic rdQ = 1'b0;
  logic [31:0] seed = 32'h0000B20E;
  logic [31:0] pattern = 32'h0000B20E;
  tcs_pkg::tcs_level_s prog [16];
  logic [47:0] probeIn;
  logic [1:0] sampleClkPins;
  logic [51:0] dispData;
  logic [9:0] dispOldest;
  logic dispFull, running, recordDone;
  logic [3:0] curLevel;
  logic [39:0] note;
  logic [15:0] prevIdx;
  logic [39:0] expQ [$];
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  trace_capture_sequencer dut (.core_clk, .rst_n, .probeIn, .sampleClkPins, .sampleClkSel,
    .sampleClkFalling, .armStart, .armRepeat, .levelProg(prog), .dispAddr, .dispData,
    .dispOldest, .dispFull, .running, .recordDone, .curLevel);
  tcs_sut_model sut (.core_clk, .pattern, .probeIn, .sampleClkPins);
  always #25 core_clk = ~core_clk;
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick
  task automatic check(string what, logic [51:0] seen, logic [51:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // Delays of FFFF keep a command quiet for any run this bench makes
  task automatic loadProg(logic [15:0] advD, logic [47:0] trMask, int stopLvl, logic [15:0] stopD);
    for (int l = 0; l < 16; l++) begin
      prog[l] = '0;
      prog[l].advDelay = advD;
      prog[l].jumpDelay = 16'hFFFF;
      prog[l].stopDelay = 16'hFFFF;
      prog[l].traceMask = trMask;
    end
    prog[stopLvl].stopDelay = stopD;
  endtask : loadProg
  task automatic arm(logic rep);
    armRepeat = rep;
    armStart = 1'b1;
    tick();
    armStart = 1'b0;
    wait (running === 1'b1);
  endtask : arm
  // Reads back to back from the oldest word, noting what each must hold
  task automatic readWords(int n, logic [1:0] step, logic anyTag);
    for (int i = 0; i < n; i++) begin
      dispAddr = (dispOldest + 10'(i)) & 10'h1FF;
      rdValid = 1'b1;
      expQ.push_back({step, i == 0, anyTag, 4'h0, pattern});
      tick();
    end
    rdValid = 1'b0;
  endtask : readWords
  // Hang guard, well above the longest expected run
  always @(posedge core_clk) begin
    rdQ <= rdValid;
    cycles++;
    if (cycles == 40000) begin
      errors++;
      tally_and_finish();
    end
  end
  // Display word settles one cycle after its address; compare mid-cycle
  always @(negedge core_clk) begin
    if (rdQ) begin
      note = expQ.pop_front();
      if (note[36]) begin
        check("tag", 52'(dispData[51:48] == 4'h3), 52'h0);
      end else begin
        check("tag", 52'(dispData[51:48]), 52'(note[35:32]));
      end
      check("pattern", 52'(dispData[47:16]), 52'(note[31:0]));
      if (!note[37]) begin
        check("index", 52'(dispData[15:0]), 52'(prevIdx + 16'(note[39:38])));
      end
      prevIdx = dispData[15:0];
    end
  end
  initial begin
    loadProg(16'hFFFF, 48'h0, 0, 16'h0258);
    repeat (2) tick();
    rst_n = 1'b1;
    // Each clock pin and edge, long enough to wrap the capture memory
    for (int m = 0; m < 4; m++) begin
      sampleClkSel = m[0];
      sampleClkFalling = m[1];
      seed = xs(seed);
      pattern = seed;
      arm(1'b0);
      check("done", 52'(recordDone), 52'h0);
      wait (recordDone === 1'b1);
      tick();
      check("full", 52'(dispFull), 52'h1);
      check("level", 52'(curLevel), 52'h0);
      readWords(512, 2'h1, 1'b0);
    end
    // Level walk with a jump past level 3, tracing even samples only
    loadProg(16'h0002, 48'h1, 5, 16'h0000);
    prog[2].jumpDelay = 16'h0001;
    prog[2].jumpTarget = 4'h4;
    arm(1'b1);
    wait (running === 1'b0);
    wait (running === 1'b1);
    armRepeat = 1'b0;
    check("again", 52'(recordDone), 52'h0);
    wait (recordDone === 1'b1);
    tick();
    check("stop level", 52'(curLevel), 52'h5);
    check("oldest", 52'({dispFull, dispOldest}), 52'h0);
    readWords(4, 2'h2, 1'b1);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire

// [tb/tcs_chk.sv]
/*
  Port checker for the trace capture sequencer.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tcs_regs.svh"
module tcs_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire tcs_pkg::tcs_level_s levelProg [`TCS_LEVELS],
  input wire logic armStart,
  input wire logic armRepeat,
  input wire logic [`TCS_ADDR_W-1:0] dispOldest,
  input wire logic dispFull,
  input wire logic running,
  input wire logic recordDone,
  input wire logic [`TCS_LVL_W-1:0] curLevel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Copy to display keeps trace control halted for a long stretch
  sequence sHalt;
    !running [*8];
  endsequence
  AST_START: assert property ($rose(running) |-> $past(armStart) || $past(armRepeat))
    else $error("run began without arming");
  AST_ENTRY: assert property ($rose(running) |-> curLevel == 4'h0)
    else $error("run did not begin at level zero");
  AST_STOP: assert property ($fell(running) |-> sHalt)
    else $error("run resumed during copy");
  AST_MOVE: assert property ($changed(curLevel) |-> running || $past(running))
    else $error("level moved while halted");
  AST_STEP: assert property (running && $past(running) && $changed(curLevel) |->
    curLevel == $past(curLevel) + 4'h1 || curLevel == levelProg[$past(curLevel)].jumpTarget)
    else $error("level moved to an unprogrammed level");
  AST_DONE: assert property (recordDone |-> !running)
    else $error("done while running");
  AST_HOLD: assert property (recordDone && !armStart |=> recordDone)
    else $error("done dropped without a start");
  AST_WRAP: assert property (!dispFull |-> dispOldest == 10'h000)
    else $error("oldest moved without a wrap");
  AST_FROZEN: assert property ($changed(dispOldest) || $changed(dispFull) |-> !running)
    else $error("display state changed while running");
endmodule : tcs_chk
bind trace_capture_sequencer tcs_chk u_chk (.core_clk, .rst_n, .levelProg, .armStart,
  .armRepeat, .dispOldest, .dispFull, .running, .recordDone, .curLevel);
`default_nettype wire

// [tb/tcs_sut_model.sv]
/*
  Probed system: free running sample clock on both pins, pin 1 inverted,
  and probe data that steps once a period. Assumes the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tcs_sut_model (
  input wire logic core_clk,
  input wire logic [31:0] pattern,
  output logic [47:0] probeIn,
  output logic [1:0] sampleClkPins
);
  logic [2:0] phase = 3'h0;
  logic [15:0] idx = 16'h0000;
  // Data moves one core cycle before pin 0 rises, so both edges see it settled
  always @(posedge core_clk) begin
    phase <= phase + 3'h1;
    if (phase == 3'h2) begin
      idx <= idx + 16'h0001;
    end
  end
  assign sampleClkPins = {~phase[2], phase[2]};
  assign probeIn = {pattern, idx};
endmodule : tcs_sut_model
`default_nettype wire
